// [common/cmp_timer_pkg.sv]
package cmp_timer_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets on the 8-bit peripheral data bus
  localparam int          ADDR_W            = 3;
  localparam logic [2:0]  OFS_CONTROL       = 3'h0;
  localparam logic [2:0]  OFS_CTL_STATUS    = 3'h1;
  localparam logic [2:0]  OFS_COUNT_HIGH    = 3'h2;
  localparam logic [2:0]  OFS_COUNT_LOW     = 3'h3;
  localparam logic [2:0]  OFS_COMPARE_HIGH  = 3'h4;
  localparam logic [2:0]  OFS_COMPARE_LOW   = 3'h5;
  localparam logic [2:0]  OFS_CLOCK_STOP_1  = 3'h6;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [15:0] COUNT_RST         = 16'h0000;
  localparam logic [15:0] COMPARE_RST       = 16'hFFFF;
  localparam logic [7:0]  CONTROL_RST       = 8'h00;
  localparam logic [7:0]  CTL_STATUS_RST    = 8'h00;
  localparam logic [7:0]  CLOCK_STOP_1_RST  = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions, timer_control_reg
  localparam int          CTL_HIGH_LEVEL    = 7;
  localparam int          CTL_HIGH_SEL_LSB  = 4;
  localparam int          CTL_HIGH_SEL_TOP  = 6;
  localparam int          CTL_LOW_LEVEL     = 3;
  localparam int          CTL_LOW_SEL_LSB   = 0;
  localparam int          CTL_LOW_SEL_TOP   = 2;

  // Field positions, timer_ctl_status_reg
  localparam int          CS_HIGH_OVF       = 7;
  localparam int          CS_HIGH_CMF       = 6;
  localparam int          CS_HIGH_OVIE      = 5;
  localparam int          CS_HIGH_CCLR      = 4;
  localparam int          CS_LOW_OVF        = 3;
  localparam int          CS_LOW_CMF        = 2;
  localparam int          CS_LOW_OVIE       = 1;
  localparam int          CS_LOW_CCLR       = 0;
  localparam logic [7:0]  CS_FLAG_MASK      = 8'hCC;

  // Field position, peripheral_clock_stop_1
  localparam int          STOP_TIMER_BIT    = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Clock-select codes (top bit 0 selects the external event)
  localparam logic [1:0]  SEL_SYS_DIV32     = 2'h0;
  localparam logic [1:0]  SEL_SYS_DIV16     = 2'h1;
  localparam logic [1:0]  SEL_SYS_DIV4      = 2'h2;
  localparam logic [1:0]  SEL_SUB_DIV4      = 2'h3;
  localparam logic [2:0]  SEL_SUB_FULL      = 3'h7;

  // Divider ratios, in input clock cycles
  localparam int          DIV_32            = 32;
  localparam int          DIV_16            = 16;
  localparam int          DIV_4             = 4;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    MODE_ACTIVE,
    MODE_SLEEP,
    MODE_WATCH,
    MODE_SUBACTIVE,
    MODE_SUBSLEEP,
    MODE_STANDBY
  } power_mode_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } cpu_req_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } edge_pulse_t;

endpackage : cmp_timer_pkg

// [hw/pin_edge_sync.sv]
`timescale 1ns/10ps
module pin_edge_sync (
  input  wire logic                        clk_sys_in,
  input  wire logic                        rst_in,
  input  wire logic                        pin_in,
  output      cmp_timer_pkg::edge_pulse_t  edge_out
);

  logic [2:0] sync_r;
  logic       level_r;

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sync_r <= 3'h0;
    end else begin
      sync_r <= {sync_r[1:0], pin_in};
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      level_r <= 1'b0;
    end else if (sync_r[1] == sync_r[2]) begin
      level_r <= sync_r[2];
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      edge_out <= '0;
    end else begin
      edge_out.rise <= (sync_r[1] == sync_r[2]) && sync_r[2] && !level_r;
      edge_out.fall <= (sync_r[1] == sync_r[2]) && !sync_r[2] && level_r;
    end
  end

endmodule : pin_edge_sync

// [hw/tick_divider.sv]
`timescale 1ns/10ps
module tick_divider (
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  input  wire logic sub_rise_in,
  output      logic tick_div32_out,
  output      logic tick_div16_out,
  output      logic tick_div4_out,
  output      logic tick_sub4_out
);

  localparam int SYS_W = $clog2(cmp_timer_pkg::DIV_32);
  localparam int SUB_W = $clog2(cmp_timer_pkg::DIV_4);

  logic [SYS_W-1:0] sys_cnt_r;
  logic [SUB_W-1:0] sub_cnt_r;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sys_cnt_r <= '0;
    end else begin
      sys_cnt_r <= sys_cnt_r + 1'b1;
    end
  end

  // Sub clock arrives as synchronised edges, so it is counted in this domain
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sub_cnt_r <= '0;
    end else if (sub_rise_in) begin
      sub_cnt_r <= sub_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      tick_div32_out <= 1'b0;
      tick_div16_out <= 1'b0;
      tick_div4_out  <= 1'b0;
      tick_sub4_out  <= 1'b0;
    end else begin
      tick_div32_out <= &sys_cnt_r;
      tick_div16_out <= &sys_cnt_r[$clog2(cmp_timer_pkg::DIV_16)-1:0];
      tick_div4_out  <= &sys_cnt_r[$clog2(cmp_timer_pkg::DIV_4)-1:0];
      tick_sub4_out  <= sub_rise_in && (&sub_cnt_r);
    end
  end

endmodule : tick_divider

// [hw/compare_timer.sv]
`timescale 1ns/10ps
// Function
// - Standby control bit 0 stops the timer, 1 runs it; resets to 1.
// - Eight-bit staging register carries 16-bit counter and compare transfers.
// - In 8-bit mode byte accesses work in any order.
// - Upper write stages; lower write loads both bytes together.
// - Counter upper read latches lower byte; next lower read returns it.
// - Compare reads return register contents directly.
// - High select top bit picks one 16-bit or two 8-bit counters.
// - Reset clears counter and controls, sets compare to all ones.
// - 16-bit match sets high flag, may interrupt, toggle pin, clear counter.
// - 16-bit wrap sets high overflow; interrupt needs both enables.
// - 8-bit halves match independently with own flag, pin, interrupt, clear.
// - Each 8-bit half wrap sets own overflow; interrupt needs both enables.
// - Four internal clocks: system /32, /16, /4 and sub clock /4.
// - Low select top bit 0 counts external event edges, edge selectable.
// - Output pins drive their level bit and invert on compare match while that half's interrupt enable input is high.
// - Match takes effect when counter advances from the matching value.
// - Sub clock count is resynchronised to system clock, one period error.
// - In sub modes only sub clock /4 advances the counter.
// - Flags set by hardware only; cleared by writing 0 after reading 1.
// - Writing an output-level bit drives that level onto the pin at once.
// - Codes 100,101,110,111 select /32,/16,/4,sub /4; top bit 0 event.
module compare_timer (
  input  wire logic                          clk_sys_in,
  input  wire logic                          rst_in,
  input  wire cmp_timer_pkg::cpu_req_t       cpu_req_in,
  output      logic [7:0]                    cpu_rdata_out,
  input  wire cmp_timer_pkg::power_mode_t    power_mode_in,
  input  wire logic                          event_count_input_in,
  input  wire logic                          event_edge_select_in,
  input  wire logic                          sub_clock_in,
  input  wire logic                          high_irq_enable_in,
  input  wire logic                          low_irq_enable_in,
  output      logic                          high_toggle_pin_out,
  output      logic                          low_toggle_pin_out,
  output      logic                          high_irq_req_out,
  output      logic                          low_irq_req_out,
  output      logic [7:0]                    peripheral_clock_stop_1_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]  timer_control_reg_r;
  logic [7:0]  timer_ctl_status_reg_r;
  logic [7:0]  peripheral_clock_stop_1_r;
  logic [15:0] count_reg_r;
  logic [15:0] compare_reg_r;
  logic [7:0]  staging_r;
  logic [7:0]  flag_seen_r;

  cmp_timer_pkg::edge_pulse_t event_edge;
  cmp_timer_pkg::edge_pulse_t sub_edge;
  logic tick_div32;
  logic tick_div16;
  logic tick_div4;
  logic tick_sub4;

  ////////////////////////////////////////////////////////////////////////////
  // Count clock sources
  pin_edge_sync u_event_sync (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .pin_in     (event_count_input_in),
    .edge_out   (event_edge)
  );

  // Sub clock is asynchronous to the system clock; costs up to one period
  pin_edge_sync u_sub_sync (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .pin_in     (sub_clock_in),
    .edge_out   (sub_edge)
  );

  tick_divider u_divider (
    .clk_sys_in     (clk_sys_in),
    .rst_in         (rst_in),
    .sub_rise_in    (sub_edge.rise),
    .tick_div32_out (tick_div32),
    .tick_div16_out (tick_div16),
    .tick_div4_out  (tick_div4),
    .tick_sub4_out  (tick_sub4)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode and clock selection
  logic [2:0] sel_high;
  logic [2:0] sel_low;
  logic       split_mode;
  logic       timer_on;
  logic       sub_only;
  logic       regs_live;
  logic       event_tick;
  logic       tick_high;
  logic       tick_low;

  assign sel_high   = timer_control_reg_r[cmp_timer_pkg::CTL_HIGH_SEL_TOP:
                                          cmp_timer_pkg::CTL_HIGH_SEL_LSB];
  assign sel_low    = timer_control_reg_r[cmp_timer_pkg::CTL_LOW_SEL_TOP:
                                          cmp_timer_pkg::CTL_LOW_SEL_LSB];
  assign split_mode = timer_control_reg_r[cmp_timer_pkg::CTL_HIGH_SEL_TOP];

  assign timer_on   = peripheral_clock_stop_1_r[cmp_timer_pkg::STOP_TIMER_BIT]
                      && (power_mode_in != cmp_timer_pkg::MODE_STANDBY);
  assign sub_only   = (power_mode_in == cmp_timer_pkg::MODE_WATCH)
                      || (power_mode_in == cmp_timer_pkg::MODE_SUBACTIVE)
                      || (power_mode_in == cmp_timer_pkg::MODE_SUBSLEEP);
  // CPU register writes other than clock stop only land in active and subactive; other modes ignore them
  assign regs_live  = timer_on
                      && ((power_mode_in == cmp_timer_pkg::MODE_ACTIVE)
                      || (power_mode_in == cmp_timer_pkg::MODE_SUBACTIVE));

  assign event_tick = event_edge_select_in ? event_edge.rise : event_edge.fall;

  function automatic logic pick_tick(input logic [2:0] sel, input logic ev,
                                     input logic t32, input logic t16,
                                     input logic t4, input logic tw);
    logic r;
    r = 1'b0;
    if (!sel[2]) begin
      r = ev;
    end else begin
      case (sel[1:0])
        cmp_timer_pkg::SEL_SYS_DIV32: r = t32;
        cmp_timer_pkg::SEL_SYS_DIV16: r = t16;
        cmp_timer_pkg::SEL_SYS_DIV4:  r = t4;
        default:                      r = tw;
      endcase
    end
    return r;
  endfunction : pick_tick

  assign tick_high = timer_on && (!sub_only || sel_high == cmp_timer_pkg::SEL_SUB_FULL)
                     && pick_tick(sel_high, event_tick, tick_div32, tick_div16,
                                  tick_div4, tick_sub4);
  assign tick_low  = timer_on && (!sub_only || sel_low == cmp_timer_pkg::SEL_SUB_FULL)
                     && pick_tick(sel_low, event_tick, tick_div32, tick_div16,
                                  tick_div4, tick_sub4);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic wr_ctl;
  logic wr_cs;
  logic wr_cnt_h;
  logic wr_cnt_l;
  logic wr_cmp_h;
  logic wr_cmp_l;
  logic wr_stop;
  logic rd_cs;
  logic rd_cnt_h;

  assign wr_ctl   = regs_live && cpu_req_in.wr && cpu_req_in.addr == cmp_timer_pkg::OFS_CONTROL;
  assign wr_cs    = regs_live && cpu_req_in.wr
                    && cpu_req_in.addr == cmp_timer_pkg::OFS_CTL_STATUS;
  assign wr_cnt_h = regs_live && cpu_req_in.wr
                    && cpu_req_in.addr == cmp_timer_pkg::OFS_COUNT_HIGH;
  assign wr_cnt_l = regs_live && cpu_req_in.wr
                    && cpu_req_in.addr == cmp_timer_pkg::OFS_COUNT_LOW;
  assign wr_cmp_h = regs_live && cpu_req_in.wr
                    && cpu_req_in.addr == cmp_timer_pkg::OFS_COMPARE_HIGH;
  assign wr_cmp_l = regs_live && cpu_req_in.wr
                    && cpu_req_in.addr == cmp_timer_pkg::OFS_COMPARE_LOW;
  // Clock stop stays writable so software can leave module standby
  assign wr_stop  = cpu_req_in.wr && cpu_req_in.addr == cmp_timer_pkg::OFS_CLOCK_STOP_1;
  assign rd_cs    = cpu_req_in.rd && cpu_req_in.addr == cmp_timer_pkg::OFS_CTL_STATUS;
  assign rd_cnt_h = cpu_req_in.rd && cpu_req_in.addr == cmp_timer_pkg::OFS_COUNT_HIGH;

  ////////////////////////////////////////////////////////////////////////////
  // Counter advance, match and overflow
  logic [7:0] cnt_h;
  logic [7:0] cnt_l;
  logic       adv_high;
  logic       adv_low;
  logic       match_high;
  logic       match_low;
  logic       clr_high;
  logic       clr_low;
  logic       ovf_high;
  logic       ovf_low;
  logic       cclr_h;
  logic       cclr_l;

  assign cnt_h  = count_reg_r[15:8];
  assign cnt_l  = count_reg_r[7:0];
  assign cclr_h = timer_ctl_status_reg_r[cmp_timer_pkg::CS_HIGH_CCLR];
  assign cclr_l = timer_ctl_status_reg_r[cmp_timer_pkg::CS_LOW_CCLR];

  always_comb begin
    adv_low  = tick_low;
    // 16-bit mode carries low into high; split mode clocks high on its own
    adv_high = split_mode ? tick_high : (tick_low && (&cnt_l));
    // Match fires on the tick that leaves the equal value
    match_low = adv_low && (cnt_l == compare_reg_r[7:0]) && !wr_cmp_l;
    if (split_mode) begin
      match_high = adv_high && (cnt_h == compare_reg_r[15:8]) && !wr_cmp_h;
      clr_high   = match_high && cclr_h;
      clr_low    = match_low && cclr_l;
    end else begin
      match_high = adv_low && (count_reg_r == compare_reg_r) && !wr_cmp_l;
      clr_high   = match_high && cclr_h;
      clr_low    = clr_high;
    end
    // A counter write in the same cycle swallows the overflow
    ovf_low  = adv_low && (&cnt_l) && !clr_low && !wr_cnt_l;
    ovf_high = adv_high && (&cnt_h) && !clr_high
               && !(split_mode ? wr_cnt_h : wr_cnt_l);
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      count_reg_r <= cmp_timer_pkg::COUNT_RST;
    end else begin
      if (!split_mode && wr_cnt_l) begin
        count_reg_r <= {staging_r, cpu_req_in.wdata};
      end else begin
        if (split_mode && wr_cnt_l) begin
          count_reg_r[7:0] <= cpu_req_in.wdata;
        end else if (clr_low) begin
          count_reg_r[7:0] <= 8'h00;
        end else if (adv_low) begin
          count_reg_r[7:0] <= cnt_l + 8'h01;
        end
        if (split_mode && wr_cnt_h) begin
          count_reg_r[15:8] <= cpu_req_in.wdata;
        end else if (clr_high) begin
          count_reg_r[15:8] <= 8'h00;
        end else if (adv_high) begin
          count_reg_r[15:8] <= cnt_h + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      compare_reg_r <= cmp_timer_pkg::COMPARE_RST;
    end else if (wr_cmp_l) begin
      if (split_mode) begin
        compare_reg_r[7:0] <= cpu_req_in.wdata;
      end else begin
        compare_reg_r <= {staging_r, cpu_req_in.wdata};
      end
    end else if (wr_cmp_h && split_mode) begin
      compare_reg_r[15:8] <= cpu_req_in.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte staging, shared by counter and compare in 16-bit mode
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      staging_r <= 8'h00;
    end else if (!split_mode && (wr_cnt_h || wr_cmp_h)) begin
      staging_r <= cpu_req_in.wdata;
    end else if (!split_mode && rd_cnt_h) begin
      staging_r <= cnt_l;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and standby registers
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      timer_control_reg_r <= cmp_timer_pkg::CONTROL_RST;
    end else if (wr_ctl) begin
      timer_control_reg_r <= cpu_req_in.wdata;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      peripheral_clock_stop_1_r <= cmp_timer_pkg::CLOCK_STOP_1_RST;
    end else if (wr_stop) begin
      peripheral_clock_stop_1_r <= cpu_req_in.wdata;
    end
  end

  assign peripheral_clock_stop_1_out = peripheral_clock_stop_1_r;

  ////////////////////////////////////////////////////////////////////////////
  // Status flags: set wins over a clear in the same cycle
  logic [7:0] flag_set;
  logic [7:0] flag_clr;

  always_comb begin
    flag_set = 8'h00;
    flag_set[cmp_timer_pkg::CS_HIGH_OVF] = ovf_high;
    flag_set[cmp_timer_pkg::CS_HIGH_CMF] = match_high;
    flag_set[cmp_timer_pkg::CS_LOW_OVF]  = ovf_low;
    flag_set[cmp_timer_pkg::CS_LOW_CMF]  = match_low;
    flag_clr = wr_cs ? (~cpu_req_in.wdata & flag_seen_r & cmp_timer_pkg::CS_FLAG_MASK)
                     : 8'h00;
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      timer_ctl_status_reg_r <= cmp_timer_pkg::CTL_STATUS_RST;
    end else if (timer_on) begin
      timer_ctl_status_reg_r <= ((timer_ctl_status_reg_r & cmp_timer_pkg::CS_FLAG_MASK
                                  & ~flag_clr) | flag_set)
                                | ((wr_cs ? cpu_req_in.wdata : timer_ctl_status_reg_r)
                                  & ~cmp_timer_pkg::CS_FLAG_MASK);
    end
  end

  // Remembers which flags software has seen at 1
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      flag_seen_r <= 8'h00;
    end else if (rd_cs) begin
      flag_seen_r <= timer_ctl_status_reg_r & cmp_timer_pkg::CS_FLAG_MASK;
    end else begin
      flag_seen_r <= flag_seen_r & ~flag_clr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Toggle pins: a control write wins over a match in the same cycle
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      high_toggle_pin_out <= 1'b0;
      low_toggle_pin_out  <= 1'b0;
    end else if (wr_ctl) begin
      high_toggle_pin_out <= cpu_req_in.wdata[cmp_timer_pkg::CTL_HIGH_LEVEL];
      low_toggle_pin_out  <= cpu_req_in.wdata[cmp_timer_pkg::CTL_LOW_LEVEL];
    end else begin
      if (match_high && high_irq_enable_in) begin
        high_toggle_pin_out <= !high_toggle_pin_out;
      end
      if (match_low && low_irq_enable_in) begin
        low_toggle_pin_out <= !low_toggle_pin_out;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request pulses to the interrupt controller
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      high_irq_req_out <= 1'b0;
      low_irq_req_out  <= 1'b0;
    end else begin
      high_irq_req_out <= high_irq_enable_in
                          && (match_high || (ovf_high
                          && timer_ctl_status_reg_r[cmp_timer_pkg::CS_HIGH_OVIE]));
      // Low half only raises requests when split
      low_irq_req_out  <= split_mode && low_irq_enable_in
                          && (match_low || (ovf_low
                          && timer_ctl_status_reg_r[cmp_timer_pkg::CS_LOW_OVIE]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered one cycle after the read strobe
  logic [7:0] rdata_nxt;

  always_comb begin
    case (cpu_req_in.addr)
      cmp_timer_pkg::OFS_CONTROL:      rdata_nxt = timer_control_reg_r;
      cmp_timer_pkg::OFS_CTL_STATUS:   rdata_nxt = timer_ctl_status_reg_r;
      cmp_timer_pkg::OFS_COUNT_HIGH:   rdata_nxt = cnt_h;
      cmp_timer_pkg::OFS_COUNT_LOW:    rdata_nxt = split_mode ? cnt_l : staging_r;
      cmp_timer_pkg::OFS_COMPARE_HIGH: rdata_nxt = compare_reg_r[15:8];
      cmp_timer_pkg::OFS_COMPARE_LOW:  rdata_nxt = compare_reg_r[7:0];
      cmp_timer_pkg::OFS_CLOCK_STOP_1: rdata_nxt = peripheral_clock_stop_1_r;
      default:                         rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cpu_rdata_out <= 8'h00;
    end else if (cpu_req_in.rd) begin
      cpu_rdata_out <= rdata_nxt;
    end
  end

endmodule : compare_timer

// [tb/compare_timer_monitor.sv]
`timescale 1ns/10ps
module compare_timer_monitor (
  input wire logic                    clk_sys_in,
  input wire logic                    rst_in,
  input wire cmp_timer_pkg::cpu_req_t cpu_req_in,
  input wire logic [7:0]              cpu_rdata_out,
  input wire logic                    high_irq_enable_in,
  input wire logic                    low_irq_enable_in,
  input wire logic                    high_toggle_pin_out,
  input wire logic                    low_toggle_pin_out,
  input wire logic                    high_irq_req_out,
  input wire logic                    low_irq_req_out,
  input wire logic [7:0]              peripheral_clock_stop_1_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  logic stop_wr;
  assign stop_wr = cpu_req_in.wr && cpu_req_in.addr == cmp_timer_pkg::OFS_CLOCK_STOP_1;
  ////////////////////////////////////////////////////////////////////////////
  a_stop_reset_value: assert property ($fell(rst_in) |->
      peripheral_clock_stop_1_out == 8'hFF)
    else $error("clock stop not all ones after reset");
  a_stop_write_load: assert property (stop_wr |=>
      peripheral_clock_stop_1_out == $past(cpu_req_in.wdata))
    else $error("clock stop write lost");
  a_stop_hold_idle: assert property (!stop_wr |=> $stable(peripheral_clock_stop_1_out))
    else $error("clock stop changed without write");
  a_rdata_hold: assert property (!cpu_req_in.rd |=> $stable(cpu_rdata_out))
    else $error("read data changed without read");
  a_unmapped_zero: assert property (cpu_req_in.rd && cpu_req_in.addr == 3'h7 |=>
      cpu_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_high_irq_single: assert property (high_irq_req_out |=> !high_irq_req_out)
    else $error("high irq longer than one cycle");
  a_high_irq_cause: assert property (high_irq_req_out |-> $past(high_irq_enable_in))
    else $error("high irq while disabled");
  a_low_irq_cause: assert property (low_irq_req_out |-> $past(low_irq_enable_in))
    else $error("low irq while disabled");
  a_high_pin_cause: assert property ($changed(high_toggle_pin_out) |->
      $past(cpu_req_in.wr) || $past(high_irq_enable_in))
    else $error("high pin changed without cause");
  a_low_pin_cause: assert property ($changed(low_toggle_pin_out) |->
      $past(cpu_req_in.wr) || $past(low_irq_enable_in))
    else $error("low pin changed without cause");
  c_high_irq: cover property (high_irq_req_out);
  c_low_irq: cover property (low_irq_req_out);
  c_pin_toggle: cover property ($changed(high_toggle_pin_out));
endmodule : compare_timer_monitor

bind compare_timer compare_timer_monitor i_mon (.clk_sys_in, .rst_in, .cpu_req_in, .cpu_rdata_out,
  .high_irq_enable_in, .low_irq_enable_in, .high_toggle_pin_out, .low_toggle_pin_out,
  .high_irq_req_out, .low_irq_req_out, .peripheral_clock_stop_1_out);

// [tb/cpu_port_model.sv]
`timescale 1ns/10ps
module cpu_port_model (
  input  wire logic                    clk_sys_in,
  input  wire logic [7:0]              rdata_in,
  output      cmp_timer_pkg::cpu_req_t req_out
);
  initial req_out = '0;
  // One-cycle strobe; callers pair high byte first and read status before clearing
  task automatic xfer(input logic w, input logic [2:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk_sys_in);
    req_out <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_sys_in);
    req_out <= '0;
    #1 q = rdata_in;
  endtask : xfer
endmodule : cpu_port_model

// [tb/compare_timer_bench.sv]
`timescale 1ns/10ps
module compare_timer_bench;
  logic                    clk_sys_in = 1'b0;
  logic                    rst_in = 1'b1;
  logic                    evt = 1'b0;
  logic                    ien = 1'b1;
  cmp_timer_pkg::power_mode_t pm = cmp_timer_pkg::MODE_ACTIVE;
  cmp_timer_pkg::cpu_req_t req;
  logic [7:0]              rdata;
  logic                    hpin, lpin, hirq, lirq;
  int                      failures = 0, samples_checked = 0, hirqs = 0, lirqs = 0;
  logic [7:0]              rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00};
  initial forever #2.5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    hirqs += int'(hirq === 1'b1);
    lirqs += int'(lirq === 1'b1);
  end
  compare_timer i_compare_timer (.clk_sys_in, .rst_in, .cpu_req_in(req), .cpu_rdata_out(rdata),
    .power_mode_in(pm), .event_count_input_in(evt),
    .event_edge_select_in(1'b1), .sub_clock_in(1'b0), .high_irq_enable_in(ien),
    .low_irq_enable_in(ien), .high_toggle_pin_out(hpin), .low_toggle_pin_out(lpin),
    .high_irq_req_out(hirq), .low_irq_req_out(lirq), .peripheral_clock_stop_1_out());
  cpu_port_model cpu (.clk_sys_in, .rdata_in(rdata), .req_out(req));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    cpu.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] q;
    cpu.xfer(1'b0, a, 8'h00, q);
    chk($sformatf("reg%0d", a), e, q);
  endtask : rd
  task automatic w16(input logic [2:0] a, input logic [15:0] d);
    wr(a, d[15:8]);
    wr(a + 3'h1, d[7:0]);
  endtask : w16
  task automatic r16(input logic [2:0] a, input logic [15:0] e);
    rd(a, e[15:8]);
    rd(a + 3'h1, e[7:0]);
  endtask : r16
  // Each level held three cycles, above the two-cycle minimum; then sync settles
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (3) @(posedge clk_sys_in) evt <= 1'b1;
      repeat (3) @(posedge clk_sys_in) evt <= 1'b0;
    end
    repeat (8) @(posedge clk_sys_in);
  endtask : pulse
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 8; i++) rd(3'(i), rv[i]);
    wr(3'h1, 8'hCC);
    rd(3'h1, 8'h00);
    wr(3'h0, 8'h80);
    chk("hpin", 8'h01, 8'(hpin));
    w16(3'h2, 16'hAA55);
    w16(3'h4, 16'hAA57);
    r16(3'h4, 16'hAA57);
    rd(3'h2, 8'hAA);
    pulse(1);
    rd(3'h3, 8'h55);
    r16(3'h2, 16'hAA56);
    wr(3'h1, 8'h10);
    pulse(1);
    rd(3'h1, 8'h10);
    pulse(1);
    rd(3'h1, 8'h54);
    chk("hpin", 8'h00, 8'(hpin));
    r16(3'h2, 16'h0000);
    wr(3'h1, 8'h30);
    w16(3'h2, 16'hFFFF);
    pulse(1);
    rd(3'h1, 8'hB8);
    chk("hirqs", 8'h02, 8'(hirqs));
    wr(3'h6, 8'hFB);
    pulse(1);
    r16(3'h2, 16'h0000);
    wr(3'h6, 8'hFF);
    wr(3'h0, 8'h70);
    wr(3'h1, 8'h01);
    wr(3'h5, 8'h03);
    wr(3'h3, 8'h02);
    wr(3'h2, 8'h11);
    pulse(2);
    rd(3'h3, 8'h00);
    rd(3'h2, 8'h11);
    rd(3'h1, 8'h05);
    chk("lpin", 8'h01, 8'(lpin));
    wr(3'h0, 8'h60);
    repeat (38) @(posedge clk_sys_in);
    wr(3'h0, 8'h70);
    rd(3'h2, 8'h1B);
    @(posedge clk_sys_in) ien <= 1'b0;
    wr(3'h3, 8'h03);
    pulse(1);
    chk("lpin", 8'h00, 8'(lpin));
    rd(3'h3, 8'h00);
    @(posedge clk_sys_in) pm <= cmp_timer_pkg::MODE_SLEEP;
    wr(3'h3, 8'h40);
    pulse(1);
    rd(3'h3, 8'h01);
    chk("lirqs", 8'h01, 8'(lirqs));
    complete_run();
  end
endmodule : compare_timer_bench
